//--- core/cpc_charger_pin_ctrl.sv
// Pin level control and status logic of a single-cell charger
`timescale 1ns/100ps

module cpc_charger_pin_ctrl #(
  parameter int BLINK_HALF_CYCLES = cpc_pkg::BLINK_HALF_CYCLES,
  parameter int INT_PULSE_CYCLES = cpc_pkg::INT_PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic source_select,
  input wire logic usb_limit_boost_enable,
  input wire logic charge_enable_n,
  input wire logic vin_above_lockout,
  input wire logic vin_below_overvoltage,
  input wire logic vin_above_sleep,
  input wire logic limit_above_30ma,
  input wire logic [1:0] power_on_config_field,
  input wire logic [2:0] input_source_limit_field,
  input wire logic [2:0] input_current_limit_pin,
  input wire logic thermistor_sense_a_ok,
  input wire logic thermistor_sense_b_ok,
  input wire logic charge_done,
  input wire logic [3:0] fault_flags,
  output logic usb_source,
  output logic input_power_good_n_o,
  output logic input_power_good_n_oe,
  output logic charge_status_o,
  output logic charge_status_oe,
  output logic interrupt_n_o,
  output logic interrupt_n_oe,
  output logic boost_mode,
  output logic charge_enable,
  output logic charge_suspended,
  output logic [2:0] input_current_limit
);

  cpc_pkg::cpc_state_s r_reg;
  cpc_pkg::cpc_state_s r_next;

  logic input_good;
  logic temp_ok;
  logic charge_req;
  logic fault_any;
  logic status_event;
  logic [2:0] usb_code;
  logic [2:0] lim_code;

  always_comb begin
    r_next = r_reg;
    input_good = vin_above_lockout & vin_below_overvoltage & vin_above_sleep & limit_above_30ma;
    temp_ok = thermistor_sense_a_ok & thermistor_sense_b_ok;
    fault_any = |fault_flags;

    // High selects a USB host, low an adapter
    r_next.usb_src = source_select;

    // Open-drain power-good: enable drives the pin low
    r_next.pg_oe = input_good;

    r_next.boost = (power_on_config_field == cpc_pkg::CFG_BOOST) && usb_limit_boost_enable;

    r_next.suspend = ~temp_ok;
    charge_req = (power_on_config_field == cpc_pkg::CFG_CHARGE) && !charge_enable_n;
    r_next.chg_en = charge_req && temp_ok;

    // Smaller code is a smaller current, so a compare picks the lower limit
    lim_code = input_current_limit_pin;
    if (input_source_limit_field < lim_code) begin
      lim_code = input_source_limit_field;
    end
    usb_code = usb_limit_boost_enable ? cpc_pkg::INPUT_CURRENT_LIMIT_PIN_500MA : cpc_pkg::INPUT_CURRENT_LIMIT_PIN_100MA;
    if (source_select && !r_next.boost && (usb_code < lim_code)) begin
      lim_code = usb_code;
    end
    r_next.input_current_limit_pin_code = lim_code;

    // Charge status state
    if (fault_any) begin
      r_next.state = cpc_pkg::CHG_FAULT;
    end else if (!r_next.chg_en) begin
      r_next.state = cpc_pkg::CHG_IDLE;
    end else if (charge_done) begin
      r_next.state = cpc_pkg::CHG_DONE;
    end else begin
      r_next.state = cpc_pkg::CHG_ACTIVE;
    end

    // Blink timer: first half period drives low so a new fault shows at once
    if (r_next.state == cpc_pkg::CHG_FAULT) begin
      if (r_reg.state != cpc_pkg::CHG_FAULT) begin
        r_next.blink_cnt = '0;
        r_next.blink_level = 1'b1;
      end else if (r_reg.blink_cnt == cpc_pkg::BLINK_CNT_W'(BLINK_HALF_CYCLES - 1)) begin
        r_next.blink_cnt = '0;
        r_next.blink_level = ~r_reg.blink_level;
      end else begin
        r_next.blink_cnt = r_reg.blink_cnt + cpc_pkg::BLINK_CNT_W'(1);
      end
    end else begin
      r_next.blink_cnt = '0;
      r_next.blink_level = 1'b0;
    end

    // Fault blink wins over the charging level
    unique case (r_next.state)
      cpc_pkg::CHG_FAULT: r_next.stat_oe = r_next.blink_level;
      cpc_pkg::CHG_ACTIVE: r_next.stat_oe = 1'b1;
      cpc_pkg::CHG_IDLE: r_next.stat_oe = 1'b0;
      cpc_pkg::CHG_DONE: r_next.stat_oe = 1'b0;
    endcase

    // Any change of charge state or power-good is reported
    status_event = (r_next.state != r_reg.state) || (r_next.pg_oe != r_reg.pg_oe);

    // Events inside a running pulse merge into it; the host rereads status anyway
    if (r_reg.int_oe) begin
      if (r_reg.int_cnt == cpc_pkg::INT_CNT_W'(INT_PULSE_CYCLES - 1)) begin
        r_next.int_oe = 1'b0;
        r_next.int_cnt = '0;
      end else begin
        r_next.int_cnt = r_reg.int_cnt + cpc_pkg::INT_CNT_W'(1);
      end
    end else if (status_event) begin
      r_next.int_oe = 1'b1;
      r_next.int_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r_reg <= cpc_pkg::STATE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Open-drain pins only ever pull low, so the data value stays zero
  logic pg_o_reg;
  logic stat_o_reg;
  logic int_o_reg;

  always_ff @(posedge clk_sys) begin
    pg_o_reg <= 1'b0;
    stat_o_reg <= 1'b0;
    int_o_reg <= 1'b0;
  end

  assign usb_source = r_reg.usb_src;
  assign input_power_good_n_o = pg_o_reg;
  assign input_power_good_n_oe = r_reg.pg_oe;
  assign charge_status_o = stat_o_reg;
  assign charge_status_oe = r_reg.stat_oe;
  assign interrupt_n_o = int_o_reg;
  assign interrupt_n_oe = r_reg.int_oe;
  assign boost_mode = r_reg.boost;
  assign charge_enable = r_reg.chg_en;
  assign charge_suspended = r_reg.suspend;
  assign input_current_limit = r_reg.input_current_limit_pin_code;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  src_select_a: assert property ($past(!sys_rst) |-> usb_source == $past(source_select))
    else $error("source type does not follow select input");

  power_good_a: assert property ($past(!sys_rst) |-> input_power_good_n_oe == $past(
      vin_above_lockout && vin_below_overvoltage && vin_above_sleep && limit_above_30ma))
    else $error("power good does not match input conditions");

  stat_levels_a: assert property ((r_reg.state != cpc_pkg::CHG_FAULT) |->
      charge_status_oe == (r_reg.state == cpc_pkg::CHG_ACTIVE))
    else $error("charge status level wrong outside fault");

  blink_hold_a: assert property ((r_reg.state == cpc_pkg::CHG_FAULT) &&
      $past(r_reg.state == cpc_pkg::CHG_FAULT) && (r_reg.blink_cnt != '0) |->
      $stable(charge_status_oe))
    else $error("charge status toggled before half blink period");

  blink_toggle_a: assert property ((r_reg.state == cpc_pkg::CHG_FAULT) &&
      (r_reg.blink_cnt == cpc_pkg::BLINK_CNT_W'(BLINK_HALF_CYCLES - 1)) && fault_any |=>
      (charge_status_oe != $past(charge_status_oe)))
    else $error("charge status missed blink toggle");

  int_width_a: assert property ($fell(interrupt_n_oe) |->
      $past(r_reg.int_cnt) == cpc_pkg::INT_CNT_W'(INT_PULSE_CYCLES - 1))
    else $error("interrupt pulse width wrong");

  int_start_a: assert property ($rose(interrupt_n_oe) |-> r_reg.int_cnt == '0)
    else $error("interrupt pulse started mid count");

  usb_limit_a: assert property ($past(!sys_rst) && $past(source_select) && !boost_mode |->
      input_current_limit <= ($past(usb_limit_boost_enable) ?
      cpc_pkg::INPUT_CURRENT_LIMIT_PIN_500MA : cpc_pkg::INPUT_CURRENT_LIMIT_PIN_100MA))
    else $error("usb host limit exceeded in buck mode");

  boost_gate_a: assert property ($past(!sys_rst) |-> boost_mode == ($past(
      power_on_config_field == cpc_pkg::CFG_BOOST) && $past(usb_limit_boost_enable)))
    else $error("boost mode gating wrong");

  charge_gate_a: assert property (charge_enable |-> $past(
      power_on_config_field == cpc_pkg::CFG_CHARGE) && !$past(charge_enable_n))
    else $error("charging enabled without config and pin");

  min_limit_a: assert property ($past(!sys_rst) |->
      (input_current_limit <= $past(input_current_limit_pin)) &&
      (input_current_limit <= $past(input_source_limit_field)))
    else $error("input limit above pin or register limit");

  temp_suspend_a: assert property ($past(!sys_rst) &&
      !($past(thermistor_sense_a_ok) && $past(thermistor_sense_b_ok)) |->
      charge_suspended && !charge_enable)
    else $error("charging not suspended on temperature");

  fault_prio_a: assert property ((r_reg.state == cpc_pkg::CHG_FAULT) |->
      charge_status_oe == r_reg.blink_level)
    else $error("fault blink not in control of status");

  // Open-drain data values must never drive the pins high
  pg_data_zero_a: assert property (input_power_good_n_o == 1'b0)
    else $error("power good data value not low");

  stat_data_zero_a: assert property (charge_status_o == 1'b0)
    else $error("charge status data value not low");

  int_data_zero_a: assert property (interrupt_n_o == 1'b0)
    else $error("interrupt data value not low");

  suspend_follow_a: assert property ($past(!sys_rst) |-> charge_suspended ==
      !($past(thermistor_sense_a_ok) && $past(thermistor_sense_b_ok)))
    else $error("suspend flag does not follow thermistor inputs");

  charge_qual_a: assert property ($past(!sys_rst) &&
      $past(power_on_config_field == cpc_pkg::CFG_CHARGE) && !$past(charge_enable_n) &&
      $past(thermistor_sense_a_ok) && $past(thermistor_sense_b_ok) |->
      charge_enable)
    else $error("charging not enabled although qualified");

  cfg_block_a: assert property ($past(!sys_rst) &&
      $past(power_on_config_field != cpc_pkg::CFG_CHARGE) |-> !charge_enable)
    else $error("charging enabled with other config code");

  fault_enter_a: assert property ($past(!sys_rst) && $past(|fault_flags) |->
      r_reg.state == cpc_pkg::CHG_FAULT)
    else $error("fault not taken into status state");

  // A new fault must show at once, not half a blink period later
  fault_first_low_a: assert property ($past(!sys_rst) && $past(|fault_flags) &&
      $past(r_reg.state != cpc_pkg::CHG_FAULT) |-> charge_status_oe)
    else $error("new fault did not pull status low");

  active_low_a: assert property ((r_reg.state == cpc_pkg::CHG_ACTIVE) |->
      charge_status_oe)
    else $error("status not low while charging");

  done_high_a: assert property ((r_reg.state == cpc_pkg::CHG_DONE) |->
      !charge_status_oe)
    else $error("status not released when complete");

  int_event_a: assert property ($past(!sys_rst) && !$past(interrupt_n_oe) &&
      $past(r_next.state != r_reg.state) |-> interrupt_n_oe)
    else $error("state change gave no interrupt pulse");

  int_bound_a: assert property (interrupt_n_oe |->
      r_reg.int_cnt <= cpc_pkg::INT_CNT_W'(INT_PULSE_CYCLES - 1))
    else $error("interrupt pulse counter overran");

  int_idle_cnt_a: assert property (!interrupt_n_oe |-> r_reg.int_cnt == '0)
    else $error("interrupt counter not cleared between pulses");

  blink_range_a: assert property (r_reg.blink_cnt <=
      cpc_pkg::BLINK_CNT_W'(BLINK_HALF_CYCLES - 1))
    else $error("blink counter overran half period");

  blink_idle_a: assert property ((r_reg.state != cpc_pkg::CHG_FAULT) |->
      (r_reg.blink_cnt == '0) && !r_reg.blink_level)
    else $error("blink timer running without fault");

  // With an adapter only the pin and register limits apply
  adapter_limit_a: assert property ($past(!sys_rst) && !$past(source_select) |->
      input_current_limit == (($past(input_source_limit_field) <
      $past(input_current_limit_pin)) ? $past(input_source_limit_field) :
      $past(input_current_limit_pin)))
    else $error("adapter limit is not the smaller limit");

endmodule

//--- inc/cpc_pkg.sv
// Package with constants and types for the charger pin control logic
package cpc_pkg;

  // Clock and timing
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int BLINK_RATE_HZ = 1;
  localparam int INT_PULSE_US = 256;
  localparam int BLINK_HALF_CYCLES = CLK_FREQ_HZ / (2 * BLINK_RATE_HZ);
  localparam int INT_PULSE_CYCLES = (INT_PULSE_US * (CLK_FREQ_HZ / 1_000_000));

  // Counter widths sized for the documented figures
  localparam int BLINK_CNT_W = 26;
  localparam int INT_CNT_W = 15;

  // Configuration field codes of the power-on configuration register bits [5:4]
  localparam logic [1:0] CFG_CHARGE = 2'h1;
  localparam logic [1:0] CFG_BOOST = 2'h2;
  localparam int CFG_FIELD_LSB = 4;
  localparam int INPUT_CURRENT_LIMIT_PIN_FIELD_LSB = 0;

  // Input current limit codes, ordered so a smaller code is a smaller limit
  localparam int INPUT_CURRENT_LIMIT_PIN_CODE_W = 3;
  localparam logic [2:0] INPUT_CURRENT_LIMIT_PIN_100MA = 3'h0;
  localparam logic [2:0] INPUT_CURRENT_LIMIT_PIN_150MA = 3'h1;
  localparam logic [2:0] INPUT_CURRENT_LIMIT_PIN_500MA = 3'h2;
  localparam logic [2:0] INPUT_CURRENT_LIMIT_PIN_900MA = 3'h3;
  localparam logic [2:0] INPUT_CURRENT_LIMIT_PIN_1200MA = 3'h4;
  localparam logic [2:0] INPUT_CURRENT_LIMIT_PIN_1500MA = 3'h5;
  localparam logic [2:0] INPUT_CURRENT_LIMIT_PIN_2000MA = 3'h6;
  localparam logic [2:0] INPUT_CURRENT_LIMIT_PIN_3000MA = 3'h7;
  localparam logic [2:0] INPUT_CURRENT_LIMIT_PIN_RESET = INPUT_CURRENT_LIMIT_PIN_100MA;

  // Charge status state, one-hot
  typedef enum logic [3:0] {
    CHG_IDLE = 4'h1,
    CHG_ACTIVE = 4'h2,
    CHG_DONE = 4'h4,
    CHG_FAULT = 4'h8
  } cpc_chg_e;

  typedef struct packed {
    cpc_chg_e state;
    logic [BLINK_CNT_W-1:0] blink_cnt;
    logic blink_level;
    logic [INT_CNT_W-1:0] int_cnt;
    logic usb_src;
    logic pg_oe;
    logic stat_oe;
    logic int_oe;
    logic boost;
    logic chg_en;
    logic suspend;
    logic [INPUT_CURRENT_LIMIT_PIN_CODE_W-1:0] input_current_limit_pin_code;
  } cpc_state_s;

  localparam cpc_state_s STATE_RESET = '{
    state: CHG_IDLE,
    blink_cnt: '0,
    blink_level: 1'b0,
    int_cnt: '0,
    usb_src: 1'b0,
    pg_oe: 1'b0,
    stat_oe: 1'b0,
    int_oe: 1'b0,
    boost: 1'b0,
    chg_en: 1'b0,
    suspend: 1'b0,
    input_current_limit_pin_code: INPUT_CURRENT_LIMIT_PIN_RESET
  };

endpackage

//--- bench/cpc_host_model.sv
// Host side model that resolves the open-drain pins and times interrupt pulses
`timescale 1ns/100ps
module cpc_host_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic power_good_o,
  input wire logic power_good_oe,
  input wire logic status_o,
  input wire logic status_oe,
  input wire logic irq_o,
  input wire logic irq_oe,
  output logic power_good_n,
  output logic status_n,
  output logic irq_n,
  output logic [7:0] irq_width,
  output logic [7:0] irq_count
);
  logic [7:0] low_cnt;
  // Released lines float to the pull-up rail, never to the last driven level
  assign power_good_n = power_good_oe ? power_good_o : 1'h1;
  assign status_n = status_oe ? status_o : 1'h1;
  assign irq_n = irq_oe ? irq_o : 1'h1;
  // A pulse is only counted once it ends, so its width is known
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      low_cnt <= 8'h0;
      irq_width <= 8'h0;
      irq_count <= 8'h0;
    end else if (!irq_n) begin
      low_cnt <= low_cnt + 8'h1;
    end else if (low_cnt != 8'h0) begin
      irq_width <= low_cnt;
      irq_count <= irq_count + 8'h1;
      low_cnt <= 8'h0;
    end
  end
endmodule

//--- bench/cpc_charger_pin_ctrl_bench.sv
// Self-checking bench of the charger pin control logic
`timescale 1ns/100ps
module cpc_charger_pin_ctrl_bench;
  localparam int HALF = 8;
  localparam int PULSE = 5;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic src = 1'h0;
  logic boost_pin = 1'h0;
  logic ce_n = 1'h1;
  logic ta = 1'h1;
  logic tb = 1'h1;
  logic done = 1'h0;
  logic [3:0] vin = 4'hf;
  logic [3:0] faults = 4'h0;
  logic [1:0] cfg = 2'h0;
  logic [2:0] reg_lim = 3'h7;
  logic [2:0] pin_lim = 3'h7;
  logic usb_source, pg_o, pg_oe, st_o, st_oe, in_o, in_oe;
  logic boost_mode, charge_enable, charge_suspended;
  logic [2:0] eff_lim;
  logic power_good_n, status_n, irq_n;
  logic [7:0] irq_width, irq_count, c0;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  cpc_charger_pin_ctrl #(.BLINK_HALF_CYCLES(HALF), .INT_PULSE_CYCLES(PULSE)) i_cpc_charger_pin_ctrl (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .source_select(src),
    .usb_limit_boost_enable(boost_pin), .charge_enable_n(ce_n),
    .vin_above_lockout(vin[0]), .vin_below_overvoltage(vin[1]),
    .vin_above_sleep(vin[2]), .limit_above_30ma(vin[3]),
    .power_on_config_field(cfg), .input_source_limit_field(reg_lim),
    .input_current_limit_pin(pin_lim), .thermistor_sense_a_ok(ta),
    .thermistor_sense_b_ok(tb), .charge_done(done), .fault_flags(faults),
    .usb_source(usb_source), .input_power_good_n_o(pg_o), .input_power_good_n_oe(pg_oe),
    .charge_status_o(st_o), .charge_status_oe(st_oe), .interrupt_n_o(in_o),
    .interrupt_n_oe(in_oe), .boost_mode(boost_mode), .charge_enable(charge_enable),
    .charge_suspended(charge_suspended), .input_current_limit(eff_lim));

  cpc_host_model i_cpc_host_model (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .power_good_o(pg_o), .power_good_oe(pg_oe),
    .status_o(st_o), .status_oe(st_oe), .irq_o(in_o), .irq_oe(in_oe),
    .power_good_n(power_good_n), .status_n(status_n), .irq_n(irq_n),
    .irq_width(irq_width), .irq_count(irq_count));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic test_power_good();
    for (int i = 0; i < 5; i++) begin
      vin = (i == 4) ? 4'hf : (4'hf & ~(4'h1 << i));
      step(1);
      check(power_good_n, (i == 4) ? 8'h0 : 8'h1);
    end
  endtask

  task automatic test_charge();
    src = 1'h1;
    step(1);
    check(usb_source, 8'h1);
    src = 1'h0;
    cfg = 2'h1;
    ce_n = 1'h0;
    step(1);
    check(usb_source, 8'h0);
    check(charge_enable, 8'h1);
    check(status_n, 8'h0);
    done = 1'h1;
    step(1);
    check(status_n, 8'h1);
    done = 1'h0;
    ce_n = 1'h1;
    step(1);
    check(charge_enable, 8'h0);
    check(status_n, 8'h1);
    ce_n = 1'h0;
    cfg = 2'h2;
    step(1);
    check(charge_enable, 8'h0);
    cfg = 2'h1;
  endtask

  task automatic test_temp();
    for (int i = 0; i < 2; i++) begin
      {ta, tb} = (i == 0) ? 2'h1 : 2'h2;
      step(1);
      check(charge_suspended, 8'h1);
      check(charge_enable, 8'h0);
      {ta, tb} = 2'h3;
      step(1);
      check(charge_suspended, 8'h0);
      check(charge_enable, 8'h1);
    end
  endtask

  // Fault raised while charging, so a stuck low level would show in the high phase
  task automatic test_fault();
    step(10);
    c0 = irq_count;
    faults = 4'h4;
    step(HALF / 2);
    check(status_n, 8'h0);
    step(HALF);
    check(status_n, 8'h1);
    step(HALF);
    check(status_n, 8'h0);
    check(irq_count, c0 + 8'h1);
    check(irq_width, 8'(PULSE));
    faults = 4'h0;
  endtask

  task automatic test_boost();
    boost_pin = 1'h1;
    for (int i = 0; i < 4; i++) begin
      cfg = 2'(i);
      step(1);
      check(boost_mode, (i == 2) ? 8'h1 : 8'h0);
    end
    boost_pin = 1'h0;
    cfg = 2'h2;
    step(1);
    check(boost_mode, 8'h0);
  endtask

  task automatic lim_case(input logic s, input logic b, input logic [2:0] p,
                          input logic [2:0] r, input logic [2:0] e);
    src = s;
    boost_pin = b;
    pin_lim = p;
    reg_lim = r;
    step(1);
    check(eff_lim, e);
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    step(20);
    sys_rst = 1'h0;
    step(2);
    test_power_good();
    test_charge();
    test_temp();
    test_fault();
    test_boost();
    cfg = 2'h0;
    lim_case(1'h1, 1'h1, 3'h7, 3'h7, 3'h2);
    lim_case(1'h1, 1'h0, 3'h7, 3'h7, 3'h0);
    lim_case(1'h0, 1'h0, 3'h3, 3'h5, 3'h3);
    lim_case(1'h0, 1'h1, 3'h6, 3'h1, 3'h1);
    final_report();
  end
endmodule
